// ---- hw/ros_pkg.sv ----
// Purpose: Shared constants and carrier types for the relay output source select block.
// Assumes: One 100 MHz system clock; status words come from logic on the same clock.
// Notes: Register offsets are byte addresses on the plain register port.
package ros_pkg;

  // Register port widths.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // Register offsets.
  localparam logic [7:0] OFS_SOURCE = 8'h00;
  localparam logic [7:0] OFS_OVERRIDE = 8'h04;
  localparam logic [7:0] OFS_FORCED = 8'h08;
  localparam logic [7:0] OFS_STATE = 8'h0C;

  // Field layout and reset values.
  localparam int SRC_W = 5;
  localparam int RELAYS = 3;
  localparam logic [4:0] SRC_RESET = 5'h02;
  localparam logic [2:0] OVERRIDE_RESET = 3'h0;
  localparam logic [15:0] FORCED_RESET = 16'h0000;
  localparam int STATE_SEL_BIT = 3;

  // Source codes for relay output one.
  localparam logic [4:0] SRC_OFF = 5'h00;
  localparam logic [4:0] SRC_ON = 5'h01;
  localparam logic [4:0] SRC_READY_RUN = 5'h02;
  localparam logic [4:0] SRC_ENABLED = 5'h04;
  localparam logic [4:0] SRC_STARTED = 5'h05;
  localparam logic [4:0] SRC_MAGNETIZED = 5'h06;
  localparam logic [4:0] SRC_RUNNING = 5'h07;
  localparam logic [4:0] SRC_READY_REF = 5'h08;
  localparam logic [4:0] SRC_SETPOINT = 5'h09;
  localparam logic [4:0] SRC_REVERSE = 5'h0A;
  localparam logic [4:0] SRC_ZERO_SPEED = 5'h0B;
  localparam logic [4:0] SRC_ABOVE_LIMIT = 5'h0C;
  localparam logic [4:0] SRC_WARNING = 5'h0D;
  localparam logic [4:0] SRC_FAULT = 5'h0E;
  localparam logic [4:0] SRC_FAULT_INV = 5'h0F;
  localparam logic [4:0] SRC_FAULT_WARN = 5'h10;
  localparam logic [4:0] SRC_OVERCURRENT = 5'h11;
  localparam logic [4:0] SRC_OVERVOLTAGE = 5'h12;
  localparam logic [4:0] SRC_DRIVE_TEMP = 5'h13;
  localparam logic [4:0] SRC_UNDERVOLTAGE = 5'h14;
  localparam logic [4:0] SRC_MOTOR_TEMP = 5'h15;
  localparam logic [4:0] SRC_BRAKE_CMD = 5'h16;
  localparam logic [4:0] SRC_LOC_TWO = 5'h17;

  // Bit positions inside the status words.
  localparam int MAIN_READY_RUN = 1;
  localparam int MAIN_READY_REF = 2;
  localparam int MAIN_FAULT = 3;
  localparam int MAIN_WARNING = 7;
  localparam int MAIN_SETPOINT = 8;
  localparam int DSW1_ENABLED = 0;
  localparam int DSW1_STARTED = 5;
  localparam int DSW1_RUNNING = 6;
  localparam int DSW1_LOC_TWO = 11;
  localparam int DSW2_MAGNETIZED = 1;
  localparam int DSW2_ABOVE_LIMIT = 10;
  localparam int SPEED_ZERO = 0;
  localparam int SPEED_REVERSE = 2;
  localparam int BRAKE_CMD = 0;

  // Fault codes that the relay can report.
  localparam logic [15:0] FLT_OVERCURRENT = 16'h2310;
  localparam logic [15:0] FLT_OVERVOLTAGE = 16'h3210;
  localparam logic [15:0] FLT_UNDERVOLTAGE = 16'h3220;
  localparam logic [15:0] FLT_IGBT_OVERLOAD = 16'h2381;
  localparam logic [15:0] FLT_BOARD_TEMP = 16'h4110;
  localparam logic [15:0] FLT_IGBT_OVERTEMP = 16'h4210;
  localparam logic [15:0] FLT_COOLING = 16'h4290;
  localparam logic [15:0] FLT_IGBT_TEMP = 16'h42F1;
  localparam logic [15:0] FLT_EXCESS_TEMP = 16'h4310;
  localparam logic [15:0] FLT_TEMP_DIFF = 16'h4380;
  localparam logic [15:0] FLT_EXT_TEMP_1 = 16'h4981;
  localparam logic [15:0] FLT_EXT_TEMP_2 = 16'h4982;

  // Drive status words travel together.
  typedef struct packed {
    logic [15:0] main_word;
    logic [15:0] drive_word_one;
    logic [15:0] drive_word_two;
    logic [15:0] speed_word;
    logic [15:0] brake_word;
  } ros_status_type;

  // Decoded fault groups.
  typedef struct packed {
    logic overcurrent;
    logic overvoltage;
    logic undervoltage;
    logic drive_temp;
    logic motor_temp;
  } ros_fault_type;

endpackage

// ---- hw/ros_relay_select.sv ----
// Purpose: Relay output source selection with per-relay override and forced values.
// Assumes: Register port master follows the plain one-cycle strobe protocol.
// Notes: Relay two and three take their normal level from ports; only relay one has a selector.
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/10ps

// Behaviour
// [R1] A 16-bit forced-value word; bits 0..2 belong to relays one to three.
// [R2] An overridden relay follows its forced-value bit, not its source.
// [R3] Override bit 1 applies the forced bit; 0 keeps normal source operation.
// [R4] Reset clears override and forced-value words; no relay stays overridden.
// [R5] A source code picks relay one's driver; default is ready to run.
// [R6] Code 0 holds relay one off, code 1 holds it on.
// [R7] Code 2 follows main status bit 1, ready to run.
// [R8] Code 4 follows drive status one bit 0, enabled.
// [R9] Code 5 follows drive status one bit 5, started.
// [R10] Code 6 follows drive status two bit 1, magnetized.
// [R11] Code 7 follows drive status one bit 6, running.
// [R12] Code 8 follows main status bit 2, ready for reference.
// [R13] Code 9 follows main status bit 8, setpoint reached.
// [R14] Codes 10 and 11 follow speed status bits 2 and 0.
// [R15] Code 12 follows drive status two bit 10, above limit.
// [R16] Code 13 follows main status bit 7, warning.
// [R17] Code 14 follows main bit 3 fault; code 15 its inverse.
// [R18] Code 16 follows fault OR warning of the main status word.
// [R19] Code 17 energizes on the overcurrent fault.
// [R20] Code 18 energizes on overvoltage, code 20 on undervoltage.
// [R21] Code 19 energizes on any listed drive temperature fault.
// [R22] Code 21 energizes on either external temperature fault.
// [R23] Code 22 follows brake control status bit 0, brake command.
// [R24] Code 23 follows drive status one bit 11, second location active.
// [R25] Relay levels are registered; undefined source codes give de-energized.
module ros_relay_select (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  input wire logic [15:0] main_status_word,
  input wire logic [15:0] drive_status_one,
  input wire logic [15:0] drive_status_two,
  input wire logic [15:0] speed_status_word,
  input wire logic [15:0] brake_status_word,
  input wire logic [15:0] active_fault_code,
  input wire logic fault_code_valid,
  input wire logic relay_two_source,
  input wire logic relay_three_source,
  output logic relay_out_one,
  output logic relay_out_two,
  output logic relay_out_three
);

  // Software-visible state.
  logic [4:0] source_select;
  logic [2:0] relay_override_enable;
  logic [15:0] relay_forced_values;

  // Bus decode strobes.
  logic write_source;
  logic write_override;
  logic write_forced;

  // Levels of the three relays, from normal mode through override to the register.
  logic relay_one_selected;
  logic [2:0] normal_levels;
  logic [2:1] port_levels;
  logic [2:0] next_relays;
  logic [2:0] relay_levels;

  // Status and fault carriers handed to the source selector.
  ros_pkg::ros_status_type status_bundle;
  ros_pkg::ros_fault_type fault_bundle;

  // Next read data, registered one cycle after the strobe.
  logic [15:0] next_rdata;

  // True when the reported fault matches the given code.
  function automatic logic fault_is(
    input logic valid,
    input logic [15:0] code,
    input logic [15:0] wanted
  );
    fault_is = valid && (code == wanted);
  endfunction

  // True when a register access at the given offset is under way.
  function automatic logic hits(
    input logic strobe,
    input logic [7:0] addr,
    input logic [7:0] offset
  );
    hits = strobe && (addr == offset);
  endfunction

  // Write decoding; each writable register has its own strobe, and the read-only state word has none.
  always_comb
  begin
    write_source = hits(reg_write, reg_addr, ros_pkg::OFS_SOURCE);
    write_override = hits(reg_write, reg_addr, ros_pkg::OFS_OVERRIDE);
    write_forced = hits(reg_write, reg_addr, ros_pkg::OFS_FORCED);
  end

  // Source select code for relay one.
  // Wider write data is cut to the field; codes 3 and above 23 are kept but read as off.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      source_select <= ros_pkg::SRC_RESET; // [R5]
    end
    else if (write_source)
    begin
      source_select <= reg_wdata[ros_pkg::SRC_W-1:0]; // [R5]
    end
  end

  // Per-relay override enables; cleared at reset so nothing starts forced.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      relay_override_enable <= ros_pkg::OVERRIDE_RESET; // [R4]
    end
    else if (write_override)
    begin
      relay_override_enable <= reg_wdata[ros_pkg::RELAYS-1:0]; // [R3]
    end
  end

  // Forced-value word is held in full, reserved bits included.
  // Keeping all 16 bits lets software read back exactly what it wrote.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      relay_forced_values <= ros_pkg::FORCED_RESET; // [R4]
    end
    else if (write_forced)
    begin
      relay_forced_values <= reg_wdata; // [R1]
    end
  end

  // Gather the status words into one carrier for the selector.
  always_comb
  begin
    status_bundle.main_word = main_status_word;
    status_bundle.drive_word_one = drive_status_one;
    status_bundle.drive_word_two = drive_status_two;
    status_bundle.speed_word = speed_status_word;
    status_bundle.brake_word = brake_status_word;
  end

  // Classify the reported fault code into the groups a relay can show.
  // A fault counts while its code is presented with the valid flag high.
  always_comb
  begin
    fault_bundle.overcurrent =
      fault_is(fault_code_valid, active_fault_code, ros_pkg::FLT_OVERCURRENT); // [R19]
    fault_bundle.overvoltage =
      fault_is(fault_code_valid, active_fault_code, ros_pkg::FLT_OVERVOLTAGE); // [R20]
    fault_bundle.undervoltage =
      fault_is(fault_code_valid, active_fault_code, ros_pkg::FLT_UNDERVOLTAGE); // [R20]
    fault_bundle.drive_temp =
      fault_is(fault_code_valid, active_fault_code, ros_pkg::FLT_IGBT_OVERLOAD)
      | fault_is(fault_code_valid, active_fault_code, ros_pkg::FLT_BOARD_TEMP)
      | fault_is(fault_code_valid, active_fault_code, ros_pkg::FLT_IGBT_OVERTEMP)
      | fault_is(fault_code_valid, active_fault_code, ros_pkg::FLT_COOLING)
      | fault_is(fault_code_valid, active_fault_code, ros_pkg::FLT_IGBT_TEMP)
      | fault_is(fault_code_valid, active_fault_code, ros_pkg::FLT_EXCESS_TEMP)
      | fault_is(fault_code_valid, active_fault_code, ros_pkg::FLT_TEMP_DIFF); // [R21]
    fault_bundle.motor_temp =
      fault_is(fault_code_valid, active_fault_code, ros_pkg::FLT_EXT_TEMP_1)
      | fault_is(fault_code_valid, active_fault_code, ros_pkg::FLT_EXT_TEMP_2); // [R22]
  end

  // Source selector for relay one, registered inside.
  ros_source_mux source_mux (
    .clk(clk),
    .rst_n(rst_n),
    .source_code(source_select),
    .status(status_bundle),
    .faults(fault_bundle),
    .selected_level(relay_one_selected)
  );

  // Normal levels of all three relays; two and three come in already chosen.
  // Their ports are registered once here so all relays share one pipeline depth.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      port_levels <= 2'h0;
    end
    else
    begin
      port_levels <= {relay_three_source, relay_two_source};
    end
  end

  // Relay one joins the others with no extra stage of its own.
  always_comb
  begin
    normal_levels = {port_levels, relay_one_selected};
  end

  // Override each relay from its forced bit when its enable is set.
  genvar gi;
  generate
    for (gi = 0; gi < ros_pkg::RELAYS; gi = gi + 1)
    begin : g_override
      always_comb
      begin
        if (relay_override_enable[gi]) // [R3]
        begin
          next_relays[gi] = relay_forced_values[gi]; // [R2]
        end
        else
        begin
          next_relays[gi] = normal_levels[gi]; // [R3]
        end
      end
    end
  endgenerate

  // Relay drivers are flip-flops, so a register write never glitches a contact.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      relay_levels <= 3'h0;
    end
    else
    begin
      relay_levels <= next_relays; // [R25]
    end
  end

  // Relay output pins come straight from the level register.
  always_comb
  begin
    relay_out_one = relay_levels[0];
    relay_out_two = relay_levels[1];
    relay_out_three = relay_levels[2];
  end

  // Read decoding; unmapped offsets and idle cycles return zero.
  always_comb
  begin
    next_rdata = 16'h0000;
    if (hits(reg_read, reg_addr, ros_pkg::OFS_SOURCE))
    begin
      next_rdata = {11'h000, source_select};
    end
    else if (hits(reg_read, reg_addr, ros_pkg::OFS_OVERRIDE))
    begin
      next_rdata = {13'h0000, relay_override_enable};
    end
    else if (hits(reg_read, reg_addr, ros_pkg::OFS_FORCED))
    begin
      next_rdata = relay_forced_values; // [R1]
    end
    else if (hits(reg_read, reg_addr, ros_pkg::OFS_STATE))
    begin
      next_rdata = {12'h000, relay_one_selected, relay_levels};
    end
  end

  // Read data stands for exactly the cycle after the read strobe.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 16'h0000;
    end
    else
    begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

// ---- hw/ros_source_mux.sv ----
// Purpose: Picks the source signal of relay output one and registers it.
// Assumes: Status and fault groups are stable on the same clock.
// Notes: One cycle from a source change to selected_level.
`timescale 1ns/10ps

module ros_source_mux (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] source_code,
  input wire ros_pkg::ros_status_type status,
  input wire ros_pkg::ros_fault_type faults,
  output logic selected_level
);

  logic next_level;

  // Decode the source code; undefined codes fall to de-energized.
  always_comb
  begin
    next_level = 1'b0;
    case (source_code)
      ros_pkg::SRC_OFF: next_level = 1'b0; // [R6]
      ros_pkg::SRC_ON: next_level = 1'b1; // [R6]
      ros_pkg::SRC_READY_RUN: next_level = status.main_word[ros_pkg::MAIN_READY_RUN]; // [R7]
      ros_pkg::SRC_ENABLED: next_level = status.drive_word_one[ros_pkg::DSW1_ENABLED]; // [R8]
      ros_pkg::SRC_STARTED: next_level = status.drive_word_one[ros_pkg::DSW1_STARTED]; // [R9]
      ros_pkg::SRC_MAGNETIZED:
        next_level = status.drive_word_two[ros_pkg::DSW2_MAGNETIZED]; // [R10]
      ros_pkg::SRC_RUNNING: next_level = status.drive_word_one[ros_pkg::DSW1_RUNNING]; // [R11]
      ros_pkg::SRC_READY_REF: next_level = status.main_word[ros_pkg::MAIN_READY_REF]; // [R12]
      ros_pkg::SRC_SETPOINT: next_level = status.main_word[ros_pkg::MAIN_SETPOINT]; // [R13]
      ros_pkg::SRC_REVERSE: next_level = status.speed_word[ros_pkg::SPEED_REVERSE]; // [R14]
      ros_pkg::SRC_ZERO_SPEED: next_level = status.speed_word[ros_pkg::SPEED_ZERO]; // [R14]
      ros_pkg::SRC_ABOVE_LIMIT:
        next_level = status.drive_word_two[ros_pkg::DSW2_ABOVE_LIMIT]; // [R15]
      ros_pkg::SRC_WARNING: next_level = status.main_word[ros_pkg::MAIN_WARNING]; // [R16]
      ros_pkg::SRC_FAULT: next_level = status.main_word[ros_pkg::MAIN_FAULT]; // [R17]
      ros_pkg::SRC_FAULT_INV: next_level = ~status.main_word[ros_pkg::MAIN_FAULT]; // [R17]
      ros_pkg::SRC_FAULT_WARN:
        next_level = status.main_word[ros_pkg::MAIN_FAULT]
                   | status.main_word[ros_pkg::MAIN_WARNING]; // [R18]
      ros_pkg::SRC_OVERCURRENT: next_level = faults.overcurrent; // [R19]
      ros_pkg::SRC_OVERVOLTAGE: next_level = faults.overvoltage; // [R20]
      ros_pkg::SRC_UNDERVOLTAGE: next_level = faults.undervoltage; // [R20]
      ros_pkg::SRC_DRIVE_TEMP: next_level = faults.drive_temp; // [R21]
      ros_pkg::SRC_MOTOR_TEMP: next_level = faults.motor_temp; // [R22]
      ros_pkg::SRC_BRAKE_CMD: next_level = status.brake_word[ros_pkg::BRAKE_CMD]; // [R23]
      ros_pkg::SRC_LOC_TWO: next_level = status.drive_word_one[ros_pkg::DSW1_LOC_TWO]; // [R24]
      default: next_level = 1'b0; // [R25]
    endcase
  end

  // Register the chosen level so the relay path has no glitches.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      selected_level <= 1'b0;
    end
    else
    begin
      selected_level <= next_level; // [R25]
    end
  end

endmodule

// ---- tb/ros_drive_model.sv ----
// Purpose: Behavioural drive status and fault source feeding the block.
// Assumes: Requests arrive just after a clock edge.
// Notes: Every untapped bit sits at the shared others level so a wrong tap shows.
`timescale 1ns/10ps

module ros_drive_model (
  input wire logic clk,
  input wire logic [2:0] word_sel,
  input wire logic [3:0] bit_sel,
  input wire logic level,
  input wire logic others,
  input wire logic [15:0] fault_in,
  input wire logic fault_on,
  output ros_pkg::ros_status_type status,
  output logic [15:0] fault_code,
  output logic fault_valid
);
  logic [79:0] flat;

  // Word zero is the main word, which sits at the top of the packed struct.
  always_comb
  begin
    flat = {80{others}};
    if (word_sel < 3'h5)
      flat[(4 - int'(word_sel)) * 16 + int'(bit_sel)] = level;
  end

  // A fault code that is not live flips every cycle, so no stale code matches.
  always @(posedge clk)
  begin
    status <= flat;
    fault_valid <= fault_on;
    fault_code <= fault_on ? fault_in : ~fault_code;
  end

  initial fault_code = 16'h0000;
endmodule

// ---- tb/ros_relay_select_properties.sv ----
// Purpose: Port-level checks of the relay output source select block.
// Assumes: Strobes follow the one-cycle register protocol.
// Notes: Shadow words track writes so each relay check can name its cause.
`timescale 1ns/10ps

module ros_relay_select_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic [15:0] main_status_word,
  input wire logic relay_two_source,
  input wire logic relay_three_source,
  input wire logic relay_out_one,
  input wire logic relay_out_two,
  input wire logic relay_out_three
);
  logic [4:0] src;
  logic [2:0] ovr;
  logic [15:0] fval;
  logic [1:0] up_cnt;
  logic settled;

  // Shadow copies of the writable words.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      src <= ros_pkg::SRC_RESET;
      ovr <= ros_pkg::OVERRIDE_RESET;
      fval <= ros_pkg::FORCED_RESET;
    end
    else if (reg_write)
    begin
      case (reg_addr)
        ros_pkg::OFS_SOURCE: src <= reg_wdata[4:0];
        ros_pkg::OFS_OVERRIDE: ovr <= reg_wdata[2:0];
        ros_pkg::OFS_FORCED: fval <= reg_wdata;
        default: ;
      endcase
    end
  end

  // The relay pipeline still holds reset values for two edges after release.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      up_cnt <= 2'h0;
    else if (up_cnt != 2'h3)
      up_cnt <= up_cnt + 2'h1;
  end

  assign settled = (up_cnt == 2'h3);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence forced_read;
    reg_read && reg_addr == ros_pkg::OFS_FORCED;
  endsequence

  sequence source_read;
    reg_read && reg_addr == ros_pkg::OFS_SOURCE;
  endsequence

  sequence normal_one;
    settled && !$past(ovr[0]);
  endsequence

  forced_read_a: assert property (forced_read |=> reg_rdata == fval)
    else $error("forced word read back differs");
  source_read_a: assert property (source_read |=> reg_rdata == {11'h000, src})
    else $error("source code read back differs");
  reset_clear_a: assert property ($rose(rst_n)
    |-> {relay_out_one, relay_out_two, relay_out_three} == 3'h0)
    else $error("relay energized right after reset");
  relay_two_a: assert property (settled
    |-> relay_out_two == ($past(ovr[1]) ? $past(fval[1]) : $past(relay_two_source, 2)))
    else $error("relay two level wrong");
  relay_three_a: assert property (settled
    |-> relay_out_three == ($past(ovr[2]) ? $past(fval[2]) : $past(relay_three_source, 2)))
    else $error("relay three level wrong");
  forced_one_a: assert property (settled && $past(ovr[0])
    |-> relay_out_one == $past(fval[0]))
    else $error("relay one ignores its forced bit");
  code_off_a: assert property (normal_one ##0 $past(src, 2) == ros_pkg::SRC_OFF
    |-> !relay_out_one)
    else $error("relay one energized on the off code");
  code_on_a: assert property (normal_one ##0 $past(src, 2) == ros_pkg::SRC_ON
    |-> relay_out_one)
    else $error("relay one idle on the on code");
  ready_run_a: assert property (normal_one ##0 $past(src, 2) == 5'h02
    |-> relay_out_one == $past(main_status_word[1], 2))
    else $error("relay one does not follow ready to run");
  fault_inv_a: assert property (normal_one ##0 $past(src, 2) == 5'h0F
    |-> relay_out_one == !$past(main_status_word[3], 2))
    else $error("relay one does not follow inverted fault");
  undefined_code_a: assert property (normal_one
    ##0 ($past(src, 2) == 5'h03 || $past(src, 2) > 5'h17) |-> !relay_out_one)
    else $error("relay one energized on an undefined code");
endmodule

// ---- tb/ros_relay_select_tb.sv ----
// Purpose: Self-checking bench for the relay output source select block.
// Assumes: One 100 MHz clock, synchronous active-low reset.
// Notes: Four edges cover the model stage plus the two relay stages.
`timescale 1ns/10ps

module ros_relay_select_tb;
  logic clk;
  logic rst_n;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [15:0] reg_rdata;
  ros_pkg::ros_status_type status;
  logic [15:0] fault_code;
  logic fault_valid;
  logic relay_two_source;
  logic relay_three_source;
  logic relay_out_one;
  logic relay_out_two;
  logic relay_out_three;
  logic [2:0] word_sel;
  logic [3:0] bit_sel;
  logic level;
  logic others;
  logic [15:0] fault_in;
  logic fault_on;
  int mismatches;
  int n_compared;
  logic [15:0] flt_val [12] = '{16'h2310, 16'h3210, 16'h3220, 16'h2381, 16'h4110, 16'h4210,
    16'h4290, 16'h42F1, 16'h4310, 16'h4380, 16'h4981, 16'h4982};
  logic [4:0] flt_src [12] = '{5'h11, 5'h12, 5'h14, 5'h13, 5'h13, 5'h13,
    5'h13, 5'h13, 5'h13, 5'h13, 5'h15, 5'h15};

  ros_drive_model ros_drive_model_i (.clk(clk), .word_sel(word_sel), .bit_sel(bit_sel),
    .level(level), .others(others), .fault_in(fault_in), .fault_on(fault_on),
    .status(status), .fault_code(fault_code), .fault_valid(fault_valid));

  ros_relay_select ros_relay_select_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .main_status_word(status.main_word), .drive_status_one(status.drive_word_one),
    .drive_status_two(status.drive_word_two), .speed_status_word(status.speed_word),
    .brake_status_word(status.brake_word), .active_fault_code(fault_code),
    .fault_code_valid(fault_valid), .relay_two_source(relay_two_source),
    .relay_three_source(relay_three_source), .relay_out_one(relay_out_one),
    .relay_out_two(relay_out_two), .relay_out_three(relay_out_three));

  // Clock at 100 MHz.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Status word and bit behind each status-driven code; word 5 means none.
  function automatic logic [6:0] tap(input logic [4:0] c);
    case (c)
      5'h02: tap = 7'h01;
      5'h04: tap = 7'h10;
      5'h05: tap = 7'h15;
      5'h06: tap = 7'h21;
      5'h07: tap = 7'h16;
      5'h08: tap = 7'h02;
      5'h09: tap = 7'h08;
      5'h0A: tap = 7'h32;
      5'h0B: tap = 7'h30;
      5'h0C: tap = 7'h2A;
      5'h0D: tap = 7'h07;
      5'h0E, 5'h0F, 5'h10: tap = 7'h03;
      5'h16: tap = 7'h40;
      5'h17: tap = 7'h1B;
      default: tap = 7'h50;
    endcase
  endfunction

  function automatic logic [15:0] relays();
    return {13'h0000, relay_out_three, relay_out_two, relay_out_one};
  endfunction

  task automatic tally_and_finish();
    if (mismatches == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask

  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask

  task automatic apply(input logic [2:0] w, input logic [3:0] b, input logic l, input logic o);
    @(posedge clk);
    word_sel <= w;
    bit_sel <= b;
    level <= l;
    others <= o;
    settle();
  endtask

  task automatic fault(input logic [15:0] f, input logic v);
    @(posedge clk);
    fault_in <= f;
    fault_on <= v;
    settle();
  endtask

  task automatic reset_defaults();
    @(posedge clk);
    rst_n <= 1'b0;
    relay_two_source <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(relays(), 16'h0000);
    rd(ros_pkg::OFS_SOURCE, 16'h0002);
    rd(ros_pkg::OFS_OVERRIDE, 16'h0000);
    rd(ros_pkg::OFS_FORCED, 16'h0000);
    apply(3'h0, 4'h1, 1'b1, 1'b0);
    chk(relays(), 16'h0001);
  endtask

  // Three passes: tap high, tap low with all else high, everything low.
  task automatic bit_sources();
    logic [6:0] t;
    logic l;
    logic o;
    logic [15:0] e;
    for (int c = 2; c < 24; c++)
    begin
      t = tap(5'(c));
      if (t[6:4] == 3'h5)
        continue;
      wr(ros_pkg::OFS_SOURCE, 16'(c));
      for (int p = 0; p < 3; p++)
      begin
        l = (p == 0);
        o = (p == 1);
        apply(t[6:4], t[3:0], l, o);
        e = {15'h0000, (c == 15) ? !l : ((c == 16) ? (l | o) : l)};
        chk(relays(), e);
      end
    end
  endtask

  task automatic fault_sources();
    for (int c = 17; c < 22; c++)
    begin
      wr(ros_pkg::OFS_SOURCE, 16'(c));
      for (int i = 0; i < 12; i++)
      begin
        fault(flt_val[i], 1'b1);
        chk(relays(), {15'h0000, flt_src[i] == 5'(c)});
        fault(flt_val[i], 1'b0);
        chk(relays(), 16'h0000);
      end
    end
  endtask

  task automatic fixed_codes();
    logic [4:0] codes [5] = '{5'h00, 5'h01, 5'h03, 5'h18, 5'h1F};
    apply(3'h5, 4'h0, 1'b1, 1'b1);
    for (int i = 0; i < 5; i++)
    begin
      wr(ros_pkg::OFS_SOURCE, {11'h000, codes[i]});
      settle();
      chk(relays(), {15'h0000, i == 1});
      rd(ros_pkg::OFS_SOURCE, {11'h000, codes[i]});
    end
  endtask

  // Forced bits are set against the sources so every override flips a relay.
  task automatic overrides();
    wr(ros_pkg::OFS_FORCED, 16'hFFFF);
    rd(ros_pkg::OFS_FORCED, 16'hFFFF);
    wr(ros_pkg::OFS_FORCED, 16'h0004);
    wr(ros_pkg::OFS_SOURCE, 16'h0001);
    relay_two_source <= 1'b1;
    relay_three_source <= 1'b0;
    wr(ros_pkg::OFS_OVERRIDE, 16'h0007);
    settle();
    chk(relays(), 16'h0004);
    rd(ros_pkg::OFS_STATE, 16'h000C);
    wr(ros_pkg::OFS_OVERRIDE, 16'h0002);
    settle();
    chk(relays(), 16'h0001);
    wr(ros_pkg::OFS_OVERRIDE, 16'h0000);
    settle();
    chk(relays(), 16'h0003);
    wr(8'h10, 16'hFFFF);
    rd(8'h10, 16'h0000);
    rd(8'h02, 16'h0000);
    wr(ros_pkg::OFS_OVERRIDE, 16'h0007);
  endtask

  // A hang counts against the run and still reaches the verdict.
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end

  initial
  begin
    mismatches = 0;
    n_compared = 0;
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    relay_two_source = 1'b0;
    relay_three_source = 1'b0;
    word_sel = 3'h5;
    bit_sel = 4'h0;
    level = 1'b0;
    others = 1'b0;
    fault_in = 16'h0000;
    fault_on = 1'b0;
    reset_defaults();
    bit_sources();
    fault_sources();
    fixed_codes();
    overrides();
    reset_defaults();
    tally_and_finish();
  end
endmodule

bind ros_relay_select ros_relay_select_properties ros_relay_select_properties_i (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .main_status_word(main_status_word), .relay_two_source(relay_two_source),
  .relay_three_source(relay_three_source), .relay_out_one(relay_out_one),
  .relay_out_two(relay_out_two), .relay_out_three(relay_out_three));
